// ===== rtl/icpc_ctrl.sv
// Interrupt control mode, NMI edge and CPU versus transfer engine priority control

// Contract
// RULE1: Mode register bits 7, 6 and 2..0 read zero and ignore writes.
// RULE2: Mode field 00 selects mode 0, 10 selects mode 2; 01, 11 forbidden.
// RULE3: Mode 0 gates maskable interrupts only by the condition code mask bit.
// RULE4: Mode 2 gates by extended mask level against source priority levels.
// RULE5: Edge select bit 3: clear means falling NMI edge, set means rising.
// RULE6: Priority control disabled: CPU always loses to transfer engines.
// RULE7: Priority control enabled lets CPU interrupt handling beat DMA transfers.
// RULE8: Enabled CPU processing takes the CPU level field, 000 low, 111 high.
// RULE9: Transfer level field gives data transfer controller priority, 000..111.
// RULE10: Each DMA channel's level comes from its own controller register.
// RULE11: Auto bit set: CPU level continuously follows the CPU interrupt mask.
// RULE12: Auto bit clear: hardware never changes the CPU level field.
// RULE13: Auto bit set: software writes to the CPU level field are ignored.
// RULE14: Source levels 000 lowest to 111 highest; NMI is never masked.
// RULE15: Mode 0 auto tracking maps mask set to level 7, clear to 0.
// RULE16: Both registers reset to zero: mode 0, falling NMI, all features off.
module icpc_ctrl
  import icpc_pkg::*;
#(
  parameter int N_DMA = 4
)(
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  nmi_pin,
  input  wire logic                  condition_code_mask,
  input  wire logic [2:0]            extended_mask_level,
  input  wire logic                  source_req_valid,
  input  wire logic [2:0]            source_req_level,
  input  wire logic [N_DMA-1:0][2:0] dma_chan_level,
  output logic                       maskable_irq,
  output logic                       nmi_request,
  output logic                       mode_is_2,
  output icpc_prio_s                 prio_levels,
  output logic                       cpu_over_xfer,
  output logic [N_DMA-1:0]           cpu_over_dma
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (N_DMA < 1 || N_DMA > 16) begin : g_bad_n_dma
    $error("N_DMA must lie between 1 and 16");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0]   interrupt_mode_control;
  logic [7:0]   cpu_transfer_priority_control;
  logic [7:0]   next_interrupt_mode_control;
  logic [7:0]   next_cpu_transfer_priority_control;
  icpc_aphase_s aphase;
  logic         take_aphase;
  logic         wr_mode;
  logic         wr_prio;
  logic [1:0]   mode_select;
  logic         nmi_edge_select;
  logic         cpu_prio_ctrl_enable;
  logic         auto_cpu_level_enable;
  logic [2:0]   cpu_level;
  logic [2:0]   xfer_ctrl_level;
  logic [2:0]   tracked_level;
  logic [1:0]   wr_mode_select;
  logic [2:0]   wr_cpu_level;
  logic [7:0]   read_byte;

  // ---------------------------------------------------------------
  // Field views
  // ---------------------------------------------------------------
  assign mode_select           = interrupt_mode_control[MODE_SEL_HI_BIT:MODE_SEL_LO_BIT];
  assign nmi_edge_select       = interrupt_mode_control[NMI_EDGE_BIT];
  assign cpu_prio_ctrl_enable  = cpu_transfer_priority_control[CPU_PRIO_EN_BIT];
  assign auto_cpu_level_enable = cpu_transfer_priority_control[AUTO_LEVEL_BIT];
  assign cpu_level             = cpu_transfer_priority_control[CPU_LEVEL_LSB +: 3];
  assign xfer_ctrl_level       = cpu_transfer_priority_control[XFER_LEVEL_LSB +: 3];
  assign wr_mode_select        = hwdata[MODE_SEL_HI_BIT:MODE_SEL_LO_BIT];
  assign wr_cpu_level          = hwdata[CPU_LEVEL_LSB +: 3];

  // ---------------------------------------------------------------
  // Bus address phase
  // ---------------------------------------------------------------
  // Only NONSEQ starts a transfer; single word transfers only, so
  // hsize carries no information this slave needs.
  assign take_aphase = hsel & hready & (htrans == HTRANS_NONSEQ);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aphase <= '0;
    end else if (hready) begin
      aphase.valid <= take_aphase;
      aphase.write <= hwrite;
      aphase.addr  <= haddr[ADDR_W-1:0];
    end
  end

  assign wr_mode = aphase.valid & aphase.write & (aphase.addr == ADDR_MODE_CTRL);
  assign wr_prio = aphase.valid & aphase.write & (aphase.addr == ADDR_PRIO_CTRL);

  // Zero wait states and always OKAY, so both stay flops held constant
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  // ---------------------------------------------------------------
  // Mode control register
  // ---------------------------------------------------------------
  // A forbidden mode code keeps the previous mode rather than leaving
  // the gating logic in an undefined state.
  always_comb begin
    next_interrupt_mode_control = interrupt_mode_control;
    if (wr_mode) begin
      next_interrupt_mode_control[NMI_EDGE_BIT] = hwdata[NMI_EDGE_BIT]; // RULE5
      if (wr_mode_select == ICPC_MODE_0 || wr_mode_select == ICPC_MODE_2) begin
        next_interrupt_mode_control[MODE_SEL_HI_BIT:MODE_SEL_LO_BIT] = wr_mode_select; // RULE2
      end
    end
    next_interrupt_mode_control = next_interrupt_mode_control & MODE_CTRL_WMASK; // RULE1
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      interrupt_mode_control <= MODE_CTRL_RESET; // RULE16
    end else begin
      interrupt_mode_control <= next_interrupt_mode_control;
    end
  end

  // ---------------------------------------------------------------
  // CPU level tracking source
  // ---------------------------------------------------------------
  always_comb begin
    case (mode_select)
      ICPC_MODE_2: tracked_level = extended_mask_level; // RULE11
      ICPC_MODE_0: tracked_level = condition_code_mask ? LEVEL_HIGHEST : LEVEL_LOWEST; // RULE15
      default:     tracked_level = LEVEL_LOWEST;
    endcase
  end

  // ---------------------------------------------------------------
  // CPU and transfer priority register
  // ---------------------------------------------------------------
  always_comb begin
    next_cpu_transfer_priority_control = cpu_transfer_priority_control;
    if (wr_prio) begin
      next_cpu_transfer_priority_control[CPU_PRIO_EN_BIT] = hwdata[CPU_PRIO_EN_BIT];
      next_cpu_transfer_priority_control[XFER_LEVEL_LSB +: 3] =
        hwdata[XFER_LEVEL_LSB +: 3]; // RULE9
      next_cpu_transfer_priority_control[AUTO_LEVEL_BIT] = hwdata[AUTO_LEVEL_BIT];
      if (!auto_cpu_level_enable) begin
        next_cpu_transfer_priority_control[CPU_LEVEL_LSB +: 3] = wr_cpu_level; // RULE13
      end
    end
    // Hardware owns the level only while tracking is on
    if (auto_cpu_level_enable) begin // RULE12
      next_cpu_transfer_priority_control[CPU_LEVEL_LSB +: 3] = tracked_level; // RULE11
    end
    // Otherwise only the software write above can change it
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cpu_transfer_priority_control <= PRIO_CTRL_RESET; // RULE16
    end else begin
      cpu_transfer_priority_control <= next_cpu_transfer_priority_control;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Read data is taken from next_ values so a read right after a write
  // sees the written value without an extra wait state.
  always_comb begin
    read_byte = 8'h00;
    if (take_aphase && !hwrite) begin
      case (haddr[ADDR_W-1:0])
        ADDR_MODE_CTRL: read_byte = next_interrupt_mode_control; // RULE1
        ADDR_PRIO_CTRL: read_byte = next_cpu_transfer_priority_control;
        default:        read_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      hrdata <= {24'h00_0000, read_byte};
    end
  end

  // ---------------------------------------------------------------
  // NMI edge detection
  // ---------------------------------------------------------------
  icpc_nmi_edge u_nmi_edge (
    .clock       (clock),
    .resetn      (resetn),
    .nmi_pin     (nmi_pin),
    .rising_sel  (nmi_edge_select),
    .nmi_request (nmi_request)
  );

  // ---------------------------------------------------------------
  // Maskable interrupt gating
  // ---------------------------------------------------------------
  // The NMI path above bypasses all of this and is never masked. RULE14
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      maskable_irq <= 1'b0;
      mode_is_2    <= 1'b0;
    end else begin
      mode_is_2 <= (mode_select == ICPC_MODE_2);
      case (mode_select)
        ICPC_MODE_0: maskable_irq <= source_req_valid & ~condition_code_mask; // RULE3
        ICPC_MODE_2: maskable_irq <= source_req_valid &
                                     (source_req_level > extended_mask_level); // RULE4 RULE14
        default:     maskable_irq <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Levels for the transfer engines
  // ---------------------------------------------------------------
  // With control off the CPU level is reported as lowest, so a
  // consumer that only compares levels still sees the CPU lose.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prio_levels <= '0;
    end else begin
      prio_levels.cpu_ctrl_en <= cpu_prio_ctrl_enable;
      prio_levels.cpu_level   <= cpu_prio_ctrl_enable ? cpu_level : LEVEL_LOWEST; // RULE6 RULE8
      prio_levels.xfer_level  <= xfer_ctrl_level; // RULE9
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cpu_over_xfer <= 1'b0;
    end else begin
      cpu_over_xfer <= cpu_prio_ctrl_enable & (cpu_level > xfer_ctrl_level); // RULE6 RULE8
    end
  end

  // Ties go to the transfer engine, matching the always-lowest default
  for (genvar ch = 0; ch < N_DMA; ch++) begin : g_dma
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        cpu_over_dma[ch] <= 1'b0;
      end else begin
        cpu_over_dma[ch] <= cpu_prio_ctrl_enable &
                            (cpu_level > dma_chan_level[ch]); // RULE7 RULE10
      end
    end
  end

endmodule

// ===== rtl/icpc_pkg.sv
// Shared constants and types of the interrupt mode and CPU priority control block
package icpc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the bus)
  // ---------------------------------------------------------------
  localparam int          ADDR_W                  = 8;
  localparam logic [7:0]  ADDR_MODE_CTRL          = 8'h00;
  localparam logic [7:0]  ADDR_PRIO_CTRL          = 8'h04;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int          MODE_SEL_HI_BIT         = 5;
  localparam int          MODE_SEL_LO_BIT         = 4;
  localparam int          NMI_EDGE_BIT            = 3;
  localparam int          CPU_PRIO_EN_BIT         = 7;
  localparam int          XFER_LEVEL_LSB          = 4;
  localparam int          AUTO_LEVEL_BIT          = 3;
  localparam int          CPU_LEVEL_LSB           = 0;
  localparam logic [7:0]  MODE_CTRL_WMASK         = 8'h38;

  // ---------------------------------------------------------------
  // Reset values and level limits
  // ---------------------------------------------------------------
  localparam logic [7:0]  MODE_CTRL_RESET         = 8'h00;
  localparam logic [7:0]  PRIO_CTRL_RESET         = 8'h00;
  localparam logic [2:0]  LEVEL_LOWEST            = 3'h0;
  localparam logic [2:0]  LEVEL_HIGHEST           = 3'h7;
  localparam logic        NMI_IDLE_LEVEL          = 1'b1;

  // ---------------------------------------------------------------
  // AHB-Lite encodings
  // ---------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ           = 2'h2;
  localparam logic        HRESP_OKAY              = 1'b0;

  typedef enum logic [1:0] {
    ICPC_MODE_0 = 2'h0,
    ICPC_MODE_2 = 2'h2
  } icpc_mode_e;

  // Priority levels handed to the transfer-engine arbitration
  typedef struct packed {
    logic       cpu_ctrl_en;
    logic [2:0] cpu_level;
    logic [2:0] xfer_level;
  } icpc_prio_s;

  // Captured address phase
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } icpc_aphase_s;

endpackage

// ===== rtl/icpc_nmi_edge.sv
// Edge detector for the non-maskable interrupt pin with selectable polarity
module icpc_nmi_edge
  import icpc_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic nmi_pin,
  input  wire logic rising_sel,
  output logic      nmi_request
);

  logic nmi_prev;

  // ---------------------------------------------------------------
  // Previous level
  // ---------------------------------------------------------------
  // Idle level after reset so the pin's resting high is no edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      nmi_prev <= NMI_IDLE_LEVEL;
    end else begin
      nmi_prev <= nmi_pin;
    end
  end

  // ---------------------------------------------------------------
  // Request pulse
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      nmi_request <= 1'b0;
    end else if (rising_sel) begin
      nmi_request <= nmi_pin & ~nmi_prev; // RULE5
    end else begin
      nmi_request <= ~nmi_pin & nmi_prev; // RULE5
    end
  end

endmodule

// ===== tb/icpc_ctrl_chk.sv
// Port-level assertions for the mode and priority control block
module icpc_ctrl_chk
  import icpc_pkg::*;
#(
  parameter int N_DMA = 4
)(
  input wire logic                  clock,
  input wire logic                  resetn,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [31:0]           hrdata,
  input wire logic                  nmi_pin,
  input wire logic                  condition_code_mask,
  input wire logic [2:0]            extended_mask_level,
  input wire logic                  source_req_valid,
  input wire logic [2:0]            source_req_level,
  input wire logic [N_DMA-1:0][2:0] dma_chan_level,
  input wire logic                  maskable_irq,
  input wire logic                  nmi_request,
  input wire logic                  mode_is_2,
  input wire icpc_prio_s            prio_levels,
  input wire logic                  cpu_over_xfer,
  input wire logic [N_DMA-1:0]      cpu_over_dma
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // --------------------
  // Sequences
  // --------------------
  sequence rd_mode_s;
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr[7:0] == ADDR_MODE_CTRL;
  endsequence
  // Mode held over two edges, so a mode change cannot blur the gating check
  sequence mode0_s;
    !mode_is_2 ##1 !mode_is_2;
  endsequence
  sequence mode2_s;
    mode_is_2 ##1 mode_is_2;
  endsequence

  resv_read_a: assert property (rd_mode_s |=>
    hrdata[7:6] == 2'h0 && hrdata[2:0] == 3'h0) else $error("reserved mode bits nonzero");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read lanes nonzero");
  irq_mode0_a: assert property (mode0_s |-> maskable_irq ==
    ($past(source_req_valid) && !$past(condition_code_mask))) else $error("mode 0 gating wrong");
  irq_mode2_a: assert property (mode2_s |-> maskable_irq ==
    ($past(source_req_valid) && $past(source_req_level) > $past(extended_mask_level)))
    else $error("mode 2 gating wrong");
  // Allows one or two cycles of latency from the pin change to the pulse
  nmi_edge_a: assert property (nmi_request |->
    $past(nmi_pin, 2) != $past(nmi_pin) || $past(nmi_pin, 3) != $past(nmi_pin, 2))
    else $error("nmi pulse without pin edge");
  nmi_pulse_a: assert property (nmi_request |=> !nmi_request)
    else $error("nmi pulse longer than one cycle");
  prio_off_a: assert property (!prio_levels.cpu_ctrl_en |-> !cpu_over_xfer &&
    cpu_over_dma == '0 && prio_levels.cpu_level == LEVEL_LOWEST) else $error("cpu not lowest");
  xfer_cmp_a: assert property (prio_levels.cpu_ctrl_en |->
    cpu_over_xfer == (prio_levels.cpu_level > prio_levels.xfer_level))
    else $error("cpu versus transfer arbitration wrong");
  dma_cmp_a: assert property (prio_levels.cpu_ctrl_en && $past(prio_levels.cpu_ctrl_en) |->
    cpu_over_dma[0] == (prio_levels.cpu_level > $past(dma_chan_level[0])))
    else $error("cpu versus dma arbitration wrong");
  // Zero wait states and OKAY on every cycle out of reset
  bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus ready or response wrong");
endmodule

bind icpc_ctrl icpc_ctrl_chk #(.N_DMA(N_DMA)) icpc_ctrl_chk_inst (.*);

// ===== tb/icpc_cpu_model.sv
// Behavioural CPU core and transfer engine side of the control block
module icpc_cpu_model
  import icpc_pkg::*;
#(
  parameter int N_DMA = 4
)(
  input  wire logic             clock,
  output logic                  nmi_pin,
  output logic                  condition_code_mask,
  output logic [2:0]            extended_mask_level,
  output logic                  source_req_valid,
  output logic [2:0]            source_req_level,
  output logic [N_DMA-1:0][2:0] dma_chan_level
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pin idles high so no edge is seen when reset lifts
  initial begin
    nmi_pin = NMI_IDLE_LEVEL;
    condition_code_mask = 1'b0;
    extended_mask_level = 3'h0;
    source_req_valid = 1'b0;
    source_req_level = 3'h0;
    dma_chan_level = '0;
  end

  // Mask state changes only at a clock edge, as the core's own flops do
  task automatic drive(input logic m, input logic [2:0] e, input logic v,
                       input logic [2:0] l, input logic [N_DMA-1:0][2:0] d);
    @(posedge clock);
    condition_code_mask <= m;
    extended_mask_level <= e;
    source_req_valid <= v;
    source_req_level <= l;
    dma_chan_level <= d;
  endtask

  task automatic set_nmi(input logic p);
    @(posedge clock);
    nmi_pin <= p;
  endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the mode and priority control block
module tb;
  import icpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int                    N_DMA  = 4;
  localparam logic [N_DMA-1:0][2:0] DMA_LV = {3'h7, 3'h5, 3'h4, 3'h0};
  logic                  clock, resetn, hready, hreadyout, hresp;
  logic                  hsel = 1'b0, hwrite = 1'b0;
  logic [31:0]           haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]            htrans = 2'h0;
  logic [2:0]            hsize = 3'h2, extended_mask_level, source_req_level;
  logic                  nmi_pin, condition_code_mask, source_req_valid;
  logic                  maskable_irq, nmi_request, mode_is_2, cpu_over_xfer;
  logic [N_DMA-1:0][2:0] dma_chan_level;
  logic [N_DMA-1:0]      cpu_over_dma;
  icpc_prio_s            prio_levels;
  int                    n_errors = 0, check_count = 0;
  // Address, write data, expected readback
  logic [23:0]           rows [7] = '{24'h00FF08, 24'h002020, 24'h001C28, 24'h000000,
                                      24'h04F7F7, 24'h0CA500, 24'h040000};

  assign hready = hreadyout;
  icpc_ctrl #(.N_DMA(N_DMA)) icpc_ctrl_inst (.*);
  icpc_cpu_model #(.N_DMA(N_DMA)) icpc_cpu_model_inst (.*);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // --------------------
  // Tasks
  // --------------------
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single AHB-Lite transfer; waits on hready with no assumed latency
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                     output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    r = hrdata;
  endtask

  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic nmi_try(input logic lvl, input logic [31:0] exp);
    logic [31:0] n;
    n = 32'h0;
    icpc_cpu_model_inst.set_nmi(lvl);
    repeat (4) begin
      @(posedge clock);
      #1;
      n = n + nmi_request;
    end
    compare(n, exp);
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    resetn = 1'b0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    bus(1'b0, ADDR_MODE_CTRL, 8'h00, rd);
    compare(rd, 32'h0);
    bus(1'b0, ADDR_PRIO_CTRL, 8'h00, rd);
    compare(rd, 32'h0);
    compare({mode_is_2, prio_levels}, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i][23:16], rows[i][15:8], rd);
      bus(1'b0, rows[i][23:16], 8'h00, rd);
      compare(rd, {24'h0, rows[i][7:0]});
    end
    icpc_cpu_model_inst.drive(1'b0, 3'h7, 1'b1, 3'h0, DMA_LV);
    settle();
    compare(maskable_irq, 1'b1);
    icpc_cpu_model_inst.drive(1'b1, 3'h0, 1'b1, 3'h7, DMA_LV);
    settle();
    compare(maskable_irq, 1'b0);
    bus(1'b1, ADDR_MODE_CTRL, 8'h20, rd);
    icpc_cpu_model_inst.drive(1'b1, 3'h4, 1'b1, 3'h5, DMA_LV);
    settle();
    compare({mode_is_2, maskable_irq}, 2'h3);
    icpc_cpu_model_inst.drive(1'b0, 3'h4, 1'b1, 3'h4, DMA_LV);
    settle();
    compare(maskable_irq, 1'b0);
    icpc_cpu_model_inst.drive(1'b0, 3'h6, 1'b0, 3'h0, DMA_LV);
    bus(1'b1, ADDR_PRIO_CTRL, 8'h88, rd);
    settle();
    bus(1'b0, ADDR_PRIO_CTRL, 8'h00, rd);
    compare(rd, 32'h8E);
    bus(1'b1, ADDR_MODE_CTRL, 8'h00, rd);
    icpc_cpu_model_inst.drive(1'b1, 3'h6, 1'b0, 3'h0, DMA_LV);
    settle();
    bus(1'b0, ADDR_PRIO_CTRL, 8'h00, rd);
    compare(rd, 32'h8F);
    // Level bits dropped: tracking was still on when this write landed
    bus(1'b1, ADDR_PRIO_CTRL, 8'hB5, rd);
    icpc_cpu_model_inst.drive(1'b0, 3'h1, 1'b0, 3'h0, DMA_LV);
    settle();
    bus(1'b0, ADDR_PRIO_CTRL, 8'h00, rd);
    compare(rd, 32'hB7);
    bus(1'b1, ADDR_PRIO_CTRL, 8'hB5, rd);
    settle();
    compare({prio_levels, cpu_over_xfer, cpu_over_dma}, 32'hD73);
    bus(1'b1, ADDR_PRIO_CTRL, 8'h35, rd);
    settle();
    compare({prio_levels, cpu_over_xfer, cpu_over_dma}, 32'h060);
    nmi_try(1'b0, 32'h1);
    nmi_try(1'b1, 32'h0);
    bus(1'b1, ADDR_MODE_CTRL, 8'h08, rd);
    settle();
    nmi_try(1'b0, 32'h0);
    nmi_try(1'b1, 32'h1);
    // Mid-run reset must clear both registers, mode_is_2 and prio_levels again
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    bus(1'b0, ADDR_MODE_CTRL, 8'h00, rd);
    compare(rd, 32'h0);
    bus(1'b0, ADDR_PRIO_CTRL, 8'h00, rd);
    compare(rd, 32'h0);
    compare({mode_is_2, prio_levels}, 32'h0);
    report_and_stop();
  end
endmodule
